/* File: verilog/ptimer_pkg.sv */
// Constants, register map and state type for the 8-bit periodic timer.
// Assumes a single core clock and the plain register port of the timer top.
// How it works
// - 8-bit up-counter fed by instruction clock through a prescaler.
// - Prescale 1:1, 1:4 or 1:16 from control bits 1..0.
// - Counter runs from zero to period, then wraps to zero next increment.
// - Period register is read/write and resets to all ones.
// - Counter register is read/write and resets to zero.
// - Each match feeds a 4-bit postscaler; completion sets match flag bit 1.
// - Control bit 2 clear stops the timer; set lets it run.
// - Counter or control writes and reset clear both scaler counters.
// - Control write leaves the counter value unchanged.
// - Pre-postscaler match pulse goes out to the sync serial port.
// - Match pulse is the PWM time base for capture/compare/PWM units.
// - Both PWM units share one period and update rate from this timer.
// - Control resets to zero; bit 7 always reads zero.
package ptimer_pkg;
    localparam logic [7:0] ADDR_IRQ_FLAGS   = 8'h0C;
    localparam logic [7:0] ADDR_COUNT       = 8'h11;
    localparam logic [7:0] ADDR_CONTROL     = 8'h12;
    localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] ADDR_PERIOD      = 8'h92;

    localparam logic [7:0] PERIOD_RESET     = 8'hFF;
    localparam logic [7:0] CONTROL_MASK     = 8'h7F;
    localparam int         FLAG_BIT         = 1;
    localparam int         ON_BIT           = 2;
    localparam int         INSTR_DIV        = 4;
    localparam logic [1:0] PRE_DIV1         = 2'h0;
    localparam logic [1:0] PRE_DIV4         = 2'h1;
    localparam logic [3:0] PRE_LAST4        = 4'h3;
    localparam logic [3:0] PRE_LAST16       = 4'hF;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] period;
        logic [7:0] control;
        logic [7:0] flags;
        logic [7:0] enables;
        logic [1:0] qdiv;
        logic [3:0] pre;
        logic [3:0] post;
        logic       match;
        logic [7:0] rdata;
    } tmr_state_s;
endpackage

/* File: verilog/ptimer.sv */
// 8-bit periodic timer with prescaler, period register and postscaler.
// Assumes core_clk is the oscillator; the instruction clock is core_clk / 4.
module ptimer (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire ptimer_pkg::reg_req_s req,
    output logic [7:0]                rdata,
    // Events
    output logic                      match_pulse,
    output logic                      irq
);
    import ptimer_pkg::*;

    tmr_state_s s_r;
    tmr_state_s s_nxt;
    logic       instr_tick;
    logic       pre_done;
    logic       inc;
    logic       at_period;
    logic       post_done;
    logic       wr_cnt;
    logic       wr_ctl;
    logic       wrap_now;
    logic       flag_set;

    localparam logic [7:0] FLAG_ONLY = 8'(1 << FLAG_BIT);

    // Register strobe decode
    function automatic logic wr_hit(input reg_req_s r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    function automatic logic rd_hit(input reg_req_s r, input logic [7:0] a);
        return r.rd && (r.addr == a);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == ADDR_COUNT || a == ADDR_CONTROL || a == ADDR_PERIOD
            || a == ADDR_IRQ_ENABLES || a == ADDR_IRQ_FLAGS;
    endfunction

    always_comb begin
        s_nxt      = s_r;
        wr_cnt     = wr_hit(req, ADDR_COUNT);
        wr_ctl     = wr_hit(req, ADDR_CONTROL);
        instr_tick = (s_r.qdiv == 2'(INSTR_DIV - 1));
        s_nxt.qdiv = s_r.qdiv + 2'h1;
        unique case (s_r.control[1:0])
            PRE_DIV1: pre_done = 1'b1;
            PRE_DIV4: pre_done = (s_r.pre == PRE_LAST4);
            default:  pre_done = (s_r.pre == PRE_LAST16);
        endcase
        inc        = s_r.control[ON_BIT] && instr_tick;
        at_period  = (s_r.count == s_r.period);
        post_done  = (s_r.post == s_r.control[6:3]);
        wrap_now   = inc && pre_done && at_period;
        flag_set   = wrap_now && post_done;
        s_nxt.match = 1'b0;
        if (inc) begin
            if (pre_done) begin
                s_nxt.pre = 4'h0;
                if (at_period) begin
                    s_nxt.count = 8'h00;
                    s_nxt.match = 1'b1;
                    s_nxt.post  = post_done ? 4'h0 : s_r.post + 4'h1;
                    if (post_done)
                        s_nxt.flags[FLAG_BIT] = 1'b1;
                end else begin
                    s_nxt.count = s_r.count + 8'h01;
                end
            end else begin
                s_nxt.pre = s_r.pre + 4'h1;
            end
        end
        if (req.wr) begin
            unique case (req.addr)
                ADDR_COUNT:       s_nxt.count   = req.wdata;
                ADDR_CONTROL:     s_nxt.control = req.wdata & CONTROL_MASK;
                ADDR_PERIOD:      s_nxt.period  = req.wdata;
                ADDR_IRQ_ENABLES: s_nxt.enables = req.wdata;
                ADDR_IRQ_FLAGS:   s_nxt.flags   = (s_r.flags & ~req.wdata) | (s_nxt.flags & ~s_r.flags);
                default:          ;
            endcase
        end
        if (wr_cnt || wr_ctl) begin
            s_nxt.pre  = 4'h0;
            s_nxt.post = 4'h0;
        end
        s_nxt.rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                ADDR_COUNT:       s_nxt.rdata = s_r.count;
                ADDR_CONTROL:     s_nxt.rdata = s_r.control & CONTROL_MASK;
                ADDR_PERIOD:      s_nxt.rdata = s_r.period;
                ADDR_IRQ_ENABLES: s_nxt.rdata = s_r.enables;
                ADDR_IRQ_FLAGS:   s_nxt.rdata = s_r.flags;
                default:          s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.period <= PERIOD_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata       = s_r.rdata;
    assign match_pulse = s_r.match;
    assign irq         = |(s_r.flags & s_r.enables);

    // Checks
    a_ctl_bit7_zero: assert property (@(posedge core_clk) disable iff (!rst_n) !s_r.control[7])
        else $error("control bit 7 set");
    a_match_wraps: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.match && !$past(req.wr) |-> s_r.count == 8'h00)
        else $error("count not zero after match");
    a_off_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s_r.control[ON_BIT] && !req.wr |=> $stable(s_r.count))
        else $error("count moved while off");
    a_ctl_keeps_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == ADDR_CONTROL |=> s_r.count == $past(s_r.count) || s_r.match
            || s_r.count == $past(s_r.count) + 8'h01)
        else $error("control write changed count");
    a_scaler_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.wr && (req.addr == ADDR_CONTROL || req.addr == ADDR_COUNT) |=> s_r.pre == 4'h0 && s_r.post == 4'h0)
        else $error("scalers not cleared");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.flags[FLAG_BIT] && !(req.wr && req.addr == ADDR_IRQ_FLAGS) |=> s_r.flags[FLAG_BIT])
        else $error("flag cleared by hardware");
    a_div1_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.control[ON_BIT] && s_r.control[1:0] == PRE_DIV1 && instr_tick && !at_period && !req.wr
            |=> s_r.count == $past(s_r.count) + 8'h01)
        else $error("1:1 prescale missed increment");
    a_post_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.match && s_r.control[6:3] == 4'h0 && !$past(req.wr) |-> s_r.flags[FLAG_BIT])
        else $error("1:1 postscale did not flag");
    a_write_period: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == ADDR_PERIOD |=> s_r.period == $past(req.wdata))
        else $error("period write lost");
    a_write_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.wr && req.addr == ADDR_COUNT |=> s_r.count == $past(req.wdata))
        else $error("count write lost");

    // Multi-step behaviours
    sequence s_ctl_wr;
        wr_hit(req, ADDR_CONTROL);
    endsequence

    sequence s_cnt_wr;
        wr_hit(req, ADDR_COUNT);
    endsequence

    sequence s_tick_gap;
        !instr_tick [*3] ##1 instr_tick;
    endsequence

    sequence s_match_gap;
        !s_r.match [*3];
    endsequence

    sequence s_period_hit;
        wrap_now;
    endsequence

    a_tick_spacing: assert property (@(posedge core_clk) disable iff (!rst_n)
        instr_tick
        |=> s_tick_gap)
        else $error("instruction tick spacing wrong");

    a_qdiv_steps: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1
        |=> s_r.qdiv == $past(s_r.qdiv) + 2'h1)
        else $error("instruction divider skipped");

    a_count_needs_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
        !instr_tick && !req.wr
        |=> $stable(s_r.count))
        else $error("count moved without tick");

    a_count_steps_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        inc && pre_done && !at_period && !req.wr
        |=> s_r.count == $past(s_r.count) + 8'h01)
        else $error("count missed increment");

    a_count_no_jump: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_hit(req, ADDR_COUNT)
        |=> s_r.count == $past(s_r.count) || s_r.count == $past(s_r.count) + 8'h01 || s_r.count == 8'h00)
        else $error("count jumped");

    a_div4_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.control[1:0] == PRE_DIV4
        |-> s_r.pre <= PRE_LAST4)
        else $error("1:4 prescaler overran");

    a_div1_no_pre: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.control[1:0] == PRE_DIV1
        |-> s_r.pre == 4'h0)
        else $error("1:1 prescaler counted");

    a_pre_holds_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        inc && !pre_done && !req.wr
        |=> $stable(s_r.count))
        else $error("count moved before prescale done");

    a_pre_counts: assert property (@(posedge core_clk) disable iff (!rst_n)
        inc && !pre_done && !req.wr
        |=> s_r.pre == $past(s_r.pre) + 4'h1)
        else $error("prescaler missed tick");

    a_pre_still: assert property (@(posedge core_clk) disable iff (!rst_n)
        !inc && !req.wr
        |=> $stable(s_r.pre))
        else $error("prescaler moved without tick");

    a_match_at_period: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.match
        |-> $past(at_period))
        else $error("match without period hit");

    a_match_on_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.match
        |-> $past(inc) && $past(pre_done))
        else $error("match off increment cycle");

    a_match_spacing: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.match
        |=> s_match_gap)
        else $error("match pulse too long");

    a_period_hit: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_period_hit
        |=> s_r.match && s_r.count == 8'h00 || s_r.match && $past(wr_cnt))
        else $error("period hit gave no match");

    a_match_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s_r.control[ON_BIT]
        |=> !s_r.match)
        else $error("match while off");

    a_off_scalers: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s_r.control[ON_BIT] && !req.wr
        |=> $stable(s_r.pre) && $stable(s_r.post))
        else $error("scalers moved while off");

    a_off_no_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        !s_r.control[ON_BIT]
        |=> !$rose(s_r.flags[FLAG_BIT]))
        else $error("flag set while off");

    a_flag_only_match: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(s_r.flags[FLAG_BIT])
        |-> s_r.match)
        else $error("flag set without match");

    a_flag_needs_post: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(s_r.flags[FLAG_BIT])
        |-> $past(post_done))
        else $error("flag set before postscale done");

    a_post_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1
        |-> s_r.post <= s_r.control[6:3])
        else $error("postscaler past its limit");

    a_post_steps: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrap_now && !post_done && !req.wr
        |=> s_r.post == $past(s_r.post) + 4'h1)
        else $error("postscaler missed match");

    a_post_wraps: assert property (@(posedge core_clk) disable iff (!rst_n)
        flag_set && !req.wr
        |=> s_r.post == 4'h0)
        else $error("postscaler did not wrap");

    a_post_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wrap_now && !req.wr
        |=> $stable(s_r.post))
        else $error("postscaler moved without match");

    a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        flag_set
        |=> s_r.flags[FLAG_BIT])
        else $error("flag set lost to clear");

    a_w1c_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_hit(req, ADDR_IRQ_FLAGS) && req.wdata[FLAG_BIT] && !flag_set
        |=> !s_r.flags[FLAG_BIT])
        else $error("flag not cleared by write");

    a_other_flags_sw: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1
        |-> ((s_r.flags & ~$past(s_r.flags)) & ~FLAG_ONLY) == 8'h00)
        else $error("other flag set by hardware");

    a_flags_w1c_other: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_hit(req, ADDR_IRQ_FLAGS)
        |=> (s_r.flags & ~FLAG_ONLY) == ($past(s_r.flags) & ~$past(req.wdata) & ~FLAG_ONLY))
        else $error("flag write not one-to-clear");

    a_flags_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_hit(req, ADDR_IRQ_FLAGS) && !flag_set
        |=> $stable(s_r.flags))
        else $error("flags changed by themselves");

    a_control_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_ctl_wr
        |=> s_r.control == ($past(req.wdata) & CONTROL_MASK))
        else $error("control write lost");

    a_control_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_hit(req, ADDR_CONTROL)
        |=> $stable(s_r.control))
        else $error("control changed without write");

    a_ctl_wr_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_hit(req, ADDR_CONTROL) && !inc
        |=> $stable(s_r.count))
        else $error("control write moved count");

    a_cnt_wr_post: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_cnt_wr
        |=> s_r.post == 4'h0 && s_r.pre == 4'h0)
        else $error("count write kept scalers");

    a_period_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_hit(req, ADDR_PERIOD)
        |=> $stable(s_r.period))
        else $error("period changed without write");

    a_enables_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_hit(req, ADDR_IRQ_ENABLES)
        |=> s_r.enables == $past(req.wdata))
        else $error("enables write lost");

    a_enables_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_hit(req, ADDR_IRQ_ENABLES)
        |=> $stable(s_r.enables))
        else $error("enables changed without write");

    a_read_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_hit(req, ADDR_COUNT)
        |=> rdata == $past(s_r.count))
        else $error("count read wrong");

    a_read_period: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_hit(req, ADDR_PERIOD)
        |=> rdata == $past(s_r.period))
        else $error("period read wrong");

    a_read_control: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_hit(req, ADDR_CONTROL)
        |=> rdata == ($past(s_r.control) & CONTROL_MASK))
        else $error("control read wrong");

    a_read_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_hit(req, ADDR_IRQ_FLAGS)
        |=> rdata == $past(s_r.flags))
        else $error("flags read wrong");

    a_read_enables: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_hit(req, ADDR_IRQ_ENABLES)
        |=> rdata == $past(s_r.enables))
        else $error("enables read wrong");

    a_read_unmapped: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.rd && !mapped(req.addr)
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !req.rd
        |=> rdata == 8'h00)
        else $error("read data outside read slot");

    a_irq_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(irq)
        |-> $past(req.wr))
        else $error("interrupt dropped by itself");

    a_irq_stays: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq && !req.wr
        |=> irq)
        else $error("interrupt not held");
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the periodic timer.
// Assumes the ptimer top and its package; bench drives the register port.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ptimer_pkg::*;
    logic       core_clk     = 1'b0;
    logic       rst_n        = 1'b0;
    reg_req_s   req          = '0;
    logic [7:0] rdata;
    logic       match_pulse;
    logic       irq;
    logic [7:0] v;
    int         fail_count   = 0;
    int         total_checks = 0;
    int         cyc          = 0;
    int         n;
    int         per;
    ptimer ptimer_i (.core_clk(core_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
                     .match_pulse(match_pulse), .irq(irq));
    always #50 core_clk = ~core_clk;
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(ADDR_PERIOD);  chk(v, PERIOD_RESET);
        rd(ADDR_COUNT);   chk(v, 8'h00);
        rd(ADDR_CONTROL); chk(v, 8'h00);
        rd(8'h33);        chk(v, 8'h00);
        wr(ADDR_CONTROL, 8'h80); rd(ADDR_CONTROL); chk(v, 8'h00);
        wr(ADDR_PERIOD, 8'h02);  rd(ADDR_PERIOD);  chk(v, 8'h02);
        // Three ticks per match; tick every 4 clocks times prescale
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CONTROL, 8'h04 | 8'(p));
            per = (p == 0) ? 12 : (p == 1) ? 48 : 192;
            repeat (2 * per) @(posedge core_clk);
            n = 0;
            repeat (10 * per) begin
                @(posedge core_clk);
                #1 if (match_pulse === 1'b1) n++;
            end
            chk(8'(n), 8'h0A);
        end
        // Postscale 2: flag on third match
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_IRQ_FLAGS, 8'h02);
        wr(ADDR_IRQ_ENABLES, 8'h02);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CONTROL, 8'h14);
        n = 0;
        while (irq !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            #1 if (match_pulse === 1'b1) n++;
        end
        chk(8'(n), 8'h03);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_IRQ_ENABLES, 8'h00);
        #1 chk(8'(irq), 8'h00);
        rd(ADDR_IRQ_FLAGS); chk(v, 8'h02);
        wr(ADDR_IRQ_ENABLES, 8'h02);
        #1 chk(8'(irq), 8'h01);
        wr(ADDR_IRQ_FLAGS, 8'h02);
        #1 chk(8'(irq), 8'h00);
        rd(ADDR_IRQ_FLAGS); chk(v, 8'h00);
        // Control write that starts the timer keeps count; stop freezes it
        wr(ADDR_PERIOD, 8'hFF);
        wr(ADDR_COUNT, 8'h55);
        wr(ADDR_CONTROL, 8'h06);
        rd(ADDR_COUNT); chk(v, 8'h55);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_COUNT);
        per = v;
        repeat (200) @(posedge core_clk);
        rd(ADDR_COUNT); chk(v, 8'(per));
        stop_test();
    end
endmodule
